// ==== logic/adc_output_data_format.sv ====
// Top: output formatter of the converter plus its serial config port.
// Assumes samples arrive with a one-cycle valid on core_clk_i; serial
// pins are asynchronous and are synchronised here.
`timescale 1ns/1ps
module adc_output_data_format
  import fmt_pkg::*;
(
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  input wire logic sample_valid_i,
  input wire logic [13:0] conversion_result_bits_i,
  input wire logic overrange_flag_i,
  input wire logic cs_n_i,
  input wire logic sck_i,
  input wire logic serial_data_in_i,
  output logic [13:0] data_o,
  output logic overrange_flag_o,
  output logic data_valid_o,
  output logic sdo_o,
  output logic sdo_oe_o
);
  import fmt_pkg::*;

  cfg_if cfg ();

  logic [1:0] cs_sync_q, cs_sync_d;
  logic [1:0] sck_sync_q, sck_sync_d;
  logic [1:0] sdi_sync_q, sdi_sync_d;
  logic sck_prev_q, sck_prev_d;
  logic sck_rise, sck_fall;
  logic sdo_oe_d, sdo_oe_q;

  // Two-flop synchronisers; only the second stage is read
  always_comb begin
    cs_sync_d = {cs_sync_q[0], cs_n_i};
    sck_sync_d = {sck_sync_q[0], sck_i};
    sdi_sync_d = {sdi_sync_q[0], serial_data_in_i};
    sck_prev_d = sck_sync_q[1];
  end

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cs_sync_q <= 2'h3;
      sck_sync_q <= 2'h0;
      sdi_sync_q <= 2'h0;
      sck_prev_q <= 1'b0;
      sdo_oe_q <= 1'b0;
    end else begin
      cs_sync_q <= cs_sync_d;
      sck_sync_q <= sck_sync_d;
      sdi_sync_q <= sdi_sync_d;
      sck_prev_q <= sck_prev_d;
      sdo_oe_q <= sdo_oe_d;
    end
  end

  // Serial clock must be well below core_clk_i/4 for edges to be seen
  assign sck_rise = sck_sync_q[1] & ~sck_prev_q;
  assign sck_fall = ~sck_sync_q[1] & sck_prev_q;

  cfg_serial_port u_port (
    .core_clk_i(core_clk_i),
    .rst_n_i(rst_n_i),
    .cs_n_s_i(cs_sync_q[1]),
    .sck_rise_i(sck_rise),
    .sck_fall_i(sck_fall),
    .serial_data_in_s_i(sdi_sync_q[1]),
    .sdo_oe_d_o(sdo_oe_d),
    .cfg(cfg.port_side)
  );

  logic [2:0] test_pattern_select;
  logic alternate_polarity_enable, output_scramble_enable;
  logic signed_coding_select;
  assign test_pattern_select = cfg.format[TP_HI:TP_LO];
  assign alternate_polarity_enable = cfg.format[ABP_BIT];
  assign output_scramble_enable = cfg.format[OUTPUT_SCRAMBLE_ENABLE_BIT];
  assign signed_coding_select = cfg.format[TWOS_BIT];

  logic phase_q, phase_d;
  logic [14:0] word_q, word_d;
  logic valid_q, valid_d;
  logic [13:0] coded;
  logic [14:0] pat;

  // Per-sample formatting: coding, scramble, polarity, then patterns.
  // Patterns bypass coding so the receiver sees the exact words.
  always_comb begin
    coded = conversion_result_bits_i;
    if (signed_coding_select && !alternate_polarity_enable) begin
      coded[13] = ~coded[13];
    end
    if (output_scramble_enable) begin
      coded[13:1] = coded[13:1] ^ {13{coded[0]}};
    end
    if (alternate_polarity_enable) begin
      coded = coded ^ ODD_MASK[13:0];
    end
    unique case (test_pattern_select)
      TP_ZERO: pat = 15'h0000;
      TP_ONE: pat = 15'h7FFF;
      TP_CHECK: pat = phase_q ? CHECK_B : CHECK_A;
      TP_ALT: pat = phase_q ? 15'h7FFF : 15'h0000;
      default: pat = {overrange_flag_i, coded};
    endcase
    phase_d = sample_valid_i ? ~phase_q : phase_q;
    word_d = sample_valid_i ? pat : word_q;
    valid_d = sample_valid_i;
  end

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      phase_q <= 1'b0;
      word_q <= 15'h0000;
      valid_q <= 1'b0;
    end else begin
      phase_q <= phase_d;
      word_q <= word_d;
      valid_q <= valid_d;
    end
  end

  assign data_o = word_q[13:0];
  assign overrange_flag_o = word_q[14];
  assign data_valid_o = valid_q;
  assign sdo_o = 1'b0;
  assign sdo_oe_o = sdo_oe_q;
endmodule

// ==== logic/fmt_pkg.sv ====
// Package: constants for the output data format block.
// Assumes a 14-bit converter result with an overrange flag.
package fmt_pkg;
  localparam int DATA_W = 14;
  localparam int WORD_W = 16;
  localparam int ADDR_W = 7;
  localparam logic [6:0] ADDR_RESET = 7'h00;
  localparam logic [6:0] ADDR_FORMAT = 7'h04;
  localparam int RESET_BIT = 7;
  localparam logic [7:0] FORMAT_RESET = 8'h00;
  localparam int TP_HI = 5;
  localparam int TP_LO = 3;
  localparam int ABP_BIT = 2;
  localparam int OUTPUT_SCRAMBLE_ENABLE_BIT = 1;
  localparam int TWOS_BIT = 0;
  localparam logic [2:0] TP_OFF = 3'h0;
  localparam logic [2:0] TP_ZERO = 3'h1;
  localparam logic [2:0] TP_ONE = 3'h3;
  localparam logic [2:0] TP_CHECK = 3'h5;
  localparam logic [2:0] TP_ALT = 3'h7;
  localparam logic [14:0] CHECK_A = 15'h55A5;
  localparam logic [14:0] CHECK_B = 15'h2A5A;
  localparam logic [14:0] ODD_MASK = 15'h2AAA;
  localparam logic [4:0] BIT_COUNT_LAST = 5'h10;
endpackage

// ==== logic/cfg_if.sv ====
// Interface: configuration fields from the serial port to the formatter.
// Assumes both ends share core_clk_i.
`timescale 1ns/1ps
interface cfg_if;
  logic [7:0] format;
  modport port_side (output format);
  modport fmt_side (input format);
endinterface

// ==== logic/cfg_serial_port.sv ====
// Serial configuration port holding the format register.
// Assumes serial pins are already synchronised to core_clk_i.
`timescale 1ns/1ps
module cfg_serial_port
  import fmt_pkg::*;
(
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  input wire logic cs_n_s_i,
  input wire logic sck_rise_i,
  input wire logic sck_fall_i,
  input wire logic serial_data_in_s_i,
  output logic sdo_oe_d_o,
  cfg_if.port_side cfg
);
  logic [4:0] cnt_q, cnt_d;
  logic [15:0] sh_q, sh_d;
  logic [7:0] fmt_q, fmt_d;
  logic [7:0] rd_q, rd_d;
  logic sdo_oe_q, sdo_oe_d;

  // Shift, decode and read back; writes take effect on the 16th edge
  always_comb begin
    cnt_d = cnt_q;
    sh_d = sh_q;
    fmt_d = fmt_q;
    rd_d = rd_q;
    sdo_oe_d = sdo_oe_q;
    if (cs_n_s_i) begin
      cnt_d = 5'h00;
      sdo_oe_d = 1'b0;
    end else begin
      if (sck_rise_i && cnt_q != BIT_COUNT_LAST) begin
        sh_d = {sh_q[14:0], serial_data_in_s_i};
        cnt_d = cnt_q + 5'h01;
        if (cnt_q == 5'h07 && sh_q[6]) begin
          rd_d = ({sh_q[5:0], serial_data_in_s_i} == ADDR_FORMAT) ?
                 fmt_q : 8'h00;
        end
        if (cnt_q == 5'h0F && !sh_q[14]) begin
          if (sh_q[13:7] == ADDR_FORMAT) begin
            fmt_d = {sh_q[6:0], serial_data_in_s_i};
          end else if (sh_q[13:7] == ADDR_RESET && sh_q[RESET_BIT-1]) begin
            fmt_d = FORMAT_RESET;
          end
        end
      end
      // Open drain: drive low for a zero bit while shifting read data
      if (sck_fall_i && cnt_q >= 5'h08 && cnt_q < BIT_COUNT_LAST
          && sh_q[cnt_q[3:0]-4'h1] ) begin
        sdo_oe_d = ~rd_q[3'h7 - cnt_q[2:0]];
      end
      if (sck_fall_i && cnt_q == BIT_COUNT_LAST) begin
        sdo_oe_d = 1'b0;
      end
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cnt_q <= 5'h00;
      sh_q <= 16'h0000;
      fmt_q <= FORMAT_RESET;
      rd_q <= 8'h00;
      sdo_oe_q <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      sh_q <= sh_d;
      fmt_q <= fmt_d;
      rd_q <= rd_d;
      sdo_oe_q <= sdo_oe_d;
    end
  end

  assign cfg.format = fmt_q;
  assign sdo_oe_d_o = sdo_oe_d;
endmodule

// ==== tb/fmt_sva.sv ====
// Checker: port timing of the output formatter.
// Assumes it is bound to the formatter top.
`timescale 1ns/1ps
module fmt_sva (
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  input wire logic sample_valid_i,
  input wire logic cs_n_i,
  input wire logic [13:0] data_o,
  input wire logic overrange_flag_o,
  input wire logic data_valid_o,
  input wire logic sdo_o,
  input wire logic sdo_oe_o
);
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!rst_n_i);
  // Sample path answers one cycle later and holds between samples
  property p_vld; sample_valid_i |=> data_valid_o; endproperty
  a_vld: assert property (p_vld)
    else $error("valid missing");
  property p_nov; !sample_valid_i |=> !data_valid_o; endproperty
  a_nov: assert property (p_nov)
    else $error("stray valid");
  property p_hd; !sample_valid_i |=> $stable(data_o); endproperty
  a_hd: assert property (p_hd)
    else $error("data moved");
  property p_ho; !sample_valid_i |=> $stable(overrange_flag_o); endproperty
  a_ho: assert property (p_ho)
    else $error("flag moved");
  // Open drain: the level never drives high
  property p_sdo; sdo_o == 1'b0; endproperty
  a_sdo: assert property (p_sdo)
    else $error("sdo high");
  // Long enough idle to cover the synchroniser delay
  property p_idle; cs_n_i [*8] |-> !sdo_oe_o; endproperty
  a_idle: assert property (p_idle)
    else $error("sdo pulled while idle");
  property p_rd; $rose(rst_n_i) |-> data_o == 14'h0000 && !data_valid_o;
  endproperty
  a_rd: assert property (p_rd)
    else $error("data not cleared");
  property p_ro; $rose(rst_n_i) |-> !overrange_flag_o && !sdo_oe_o;
  endproperty
  a_ro: assert property (p_ro)
    else $error("flag not cleared");
endmodule

// ==== tb/sample_rx.sv ====
// Receiver model: captures each formatted output word.
// Assumes data and flag are settled while the valid is high.
`timescale 1ns/1ps
module sample_rx (
  input wire logic core_clk_i,
  input wire logic valid_i,
  input wire logic [14:0] word_i,
  output logic [14:0] word_o
);
  // Latch only on valid, so a lost strobe leaves a stale word
  always_ff @(posedge core_clk_i) if (valid_i) word_o <= word_i;
endmodule

// ==== tb/adc_output_data_format_test.sv ====
// Testbench: format register over the serial port, formatted samples.
// Assumes an external pull-up on the open-drain readback line.
`timescale 1ns/1ps
module adc_output_data_format_test;
  import fmt_pkg::*;
  logic clk = 0, rst_n = 0, vld = 0, of = 0, cs_n = 1, sck = 0, serial_data_in = 0;
  logic [13:0] din = 14'h0000, dq;
  logic ofq, dv, sdo, oe, ph = 0;
  logic [14:0] rxw;
  logic [7:0] rd;
  logic [7:0] fl [11] = '{8'h08, 8'h18, 8'h28, 8'h38, 8'h01, 8'h02,
    8'h04, 8'h05, 8'h07, 8'h06, 8'h03};
  logic [15:0] rq [4] = '{16'h8415, 16'h05FF, 16'h0429, 16'h0429};
  int nq [4] = '{16, 16, 10, 20};
  logic [7:0] eq [4] = '{8'h03, 8'h03, 8'h03, 8'h29};
  int err_total = 0, checks_done = 0;
  adc_output_data_format i_dut (.core_clk_i(clk), .rst_n_i(rst_n),
    .sample_valid_i(vld), .conversion_result_bits_i(din),
    .overrange_flag_i(of), .cs_n_i(cs_n), .sck_i(sck),
    .serial_data_in_i(serial_data_in), .data_o(dq), .overrange_flag_o(ofq),
    .data_valid_o(dv), .sdo_o(sdo), .sdo_oe_o(oe));
  sample_rx i_rx (.core_clk_i(clk), .valid_i(dv), .word_i({ofq, dq}),
    .word_o(rxw));
  initial forever #12.5 clk = ~clk;
  task chk(input logic [15:0] g, input logic [15:0] e);
    checks_done++;
    if (g !== e) begin
      err_total++;
      $display("mismatch t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task cyc(input int n);
    repeat (n) @(negedge clk);
  endtask
  // Frame of n rising edges; readback bit is the inverse of the pull-down
  task xfer(input logic [15:0] w, input int n);
    cs_n = 0;
    for (int i = 0; i < n; i++) begin
      sck = 0;
      serial_data_in = i < 16 ? w[15 - i] : 1'b1;
      cyc(6);
      if (i >= 8 && i < 16) rd[15 - i] = ~oe;
      sck = 1;
      cyc(6);
    end
    sck = 0;
    cyc(6);
    cs_n = 1;
    cyc(8);
  endtask
  // Patterns ignore the data path; coding steps apply otherwise
  function automatic logic [15:0] exp_w(logic [7:0] f, logic [13:0] d,
    logic o, logic p);
    logic [2:0] tp;
    tp = f[TP_HI:TP_LO];
    if (tp == TP_ZERO) return 16'h0000;
    if (tp == TP_ONE) return 16'h7FFF;
    if (tp == TP_CHECK) return p ? {1'b0, CHECK_B} : {1'b0, CHECK_A};
    if (tp == TP_ALT) return p ? 16'h7FFF : 16'h0000;
    if (f[OUTPUT_SCRAMBLE_ENABLE_BIT]) d[13:1] = d[13:1] ^ {13{d[0]}};
    if (f[ABP_BIT]) d = d ^ 14'h2AAA;
    else if (f[TWOS_BIT]) d[13] = ~d[13];
    return {1'b0, o, d};
  endfunction
  task smp(input logic [7:0] f, input logic [13:0] d, input logic o);
    din = d;
    of = o;
    vld = 1;
    cyc(1);
    vld = 0;
    chk(dv, 1'b1);
    cyc(1);
    chk(rxw, exp_w(f, d, o, ph));
    ph = ~ph;
  endtask
  task finish_test;
    $display("checks %0d mismatches %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  // Main sequence; the pattern phase is tracked from the pin reset only
  initial begin
    cyc(12);
    rst_n = 1;
    cyc(4);
    xfer(16'h8400, 16);
    chk(rd, FORMAT_RESET);
    smp(8'h00, 14'h1234, 1'b1);
    foreach (fl[k]) begin
      xfer({8'h04, fl[k]}, 16);
      xfer(16'h8400, 16);
      chk(rd, fl[k]);
      smp(fl[k], 14'h2C35, 1'b0);
      smp(fl[k], 14'h1A4A, 1'b1);
    end
    $display("test formats done");
    foreach (rq[k]) begin
      xfer(rq[k], nq[k]);
      xfer(16'h8400, 16);
      chk(rd, eq[k]);
    end
    xfer(16'h0080, 16);
    xfer(16'h8400, 16);
    chk(rd, FORMAT_RESET);
    xfer(16'h0401, 16);
    xfer(16'h8400, 16);
    chk(rd, 8'h01);
    $display("test serial done");
    finish_test;
  end
endmodule
bind adc_output_data_format fmt_sva i_sva (.core_clk_i(core_clk_i),
  .rst_n_i(rst_n_i), .sample_valid_i(sample_valid_i), .cs_n_i(cs_n_i),
  .data_o(data_o), .overrange_flag_o(overrange_flag_o),
  .data_valid_o(data_valid_o), .sdo_o(sdo_o), .sdo_oe_o(sdo_oe_o));
